// >>> src/clkbuf_cfg_pkg.sv
/*
 Shared constants and carrier types for the clock buffer configuration byte bank.
 Assumes one core clock domain and an SMBus byte engine that hands over decoded bytes.
*/
package clkbuf_cfg_pkg;

    // ------------------------------------------------------------------
    // Byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PLL_AMP    = 8'h01;
    localparam logic [7:0] OFS_SLEW       = 8'h02;
    localparam logic [7:0] OFS_FREQ       = 8'h03;
    localparam logic [7:0] OFS_RSVD       = 8'h04;
    localparam logic [7:0] OFS_REV_MAKER  = 8'h05;
    localparam logic [7:0] OFS_TYPE_PART  = 8'h06;
    localparam logic [7:0] OFS_RD_LEN     = 8'h07;

    // ------------------------------------------------------------------
    // Reset values, writable masks, fixed read values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PLL_AMP    = 8'h06;
    localparam logic [7:0] WMASK_PLL_AMP  = 8'h3B;
    localparam logic [7:0] FIX_PLL_AMP    = 8'h04;
    localparam logic [7:0] RST_SLEW       = 8'hFF;
    localparam logic [7:0] WMASK_SLEW     = 8'hFF;
    localparam logic [7:0] RST_FREQ       = 8'hC7;
    localparam logic [7:0] WMASK_FREQ     = 8'h39;
    localparam logic [7:0] FIX_FREQ       = 8'hC6;
    localparam logic [7:0] RSVD_VALUE     = 8'hFF;
    localparam logic [7:0] RST_RD_LEN     = 8'h08;
    localparam logic [7:0] WMASK_RD_LEN   = 8'h1F;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
    localparam logic [7:0] NO_DATA_VALUE  = 8'hFF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PLL_RB_HI   = 7;
    localparam int PLL_RB_LO   = 6;
    localparam int PLL_SW_SEL  = 5;
    localparam int PLL_SW_HI   = 4;
    localparam int PLL_SW_LO   = 3;
    localparam int AMP_HI      = 1;
    localparam int AMP_LO      = 0;
    localparam int FSEL_EN     = 5;
    localparam int FCODE_HI    = 4;
    localparam int FCODE_LO    = 3;
    localparam int FB_SLEW     = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_INDEX,
        OP_WRITE,
        OP_READ_START,
        OP_READ,
        OP_STOP
    } op_type;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_WR_COUNT,
        PH_WR_DATA,
        PH_RD_COUNT,
        PH_RD_DATA
    } phase_type;

    typedef struct packed {
        logic       valid;
        op_type     op;
        logic [7:0] data;
    } req_type;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [7:0] data;
    } rsp_type;

    typedef struct packed {
        logic [1:0] pll_mode;
        logic [1:0] amplitude;
        logic [7:0] out_edge_rate;
        logic       fb_edge_rate;
        logic       freq_change_en;
        logic [1:0] freq_code;
    } ctrl_type;

endpackage

// >>> src/strap_sync.sv
/*
 Two flip-flop synchroniser for a group of static pin levels.
 Assumes the inputs change rarely and need no coherence between bits.
*/
`timescale 1ns/100ps
module strap_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Pin side and synchronised side
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.meta   = pin_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_out = st_r.stable;
endmodule // strap_sync

// >>> src/cfg_byte_reg.sv
/*
 One configuration byte with a writable mask; bits outside the mask read from ro_bits.
 Assumes the caller decodes the write strobe and supplies fixed or live read-only bits.
*/
`timescale 1ns/100ps
module cfg_byte_reg #(
    parameter logic [7:0] RESET = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Write side
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    // Read side
    input  wire logic [7:0] ro_bits,
    output logic      [7:0] q
);
    typedef struct packed {
        logic [7:0] val;
    } byte_state_type;

    byte_state_type st_r;
    byte_state_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // Only masked bits take writes, the rest keep their reset value
        if (we)
            st_nxt.val = (wdata & WMASK) | (st_r.val & ~WMASK);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= RESET;
        else
            st_r <= st_nxt;
    end

    assign q = (st_r.val & WMASK) | (ro_bits & ~WMASK);
endmodule // cfg_byte_reg

// >>> src/clock_buffer_cfg_bank.sv
/*
 Configuration and identification byte bank of an eight-output clock buffer.
 Assumes an SMBus byte engine on core_clk that decodes start, address and stop
 and passes index, data, read-request and stop events one cycle at a time.
*/
// What this block does
// - Strap-latched PLL mode reads back in byte1[7:6]
// - Software-select bit picks strap or software mode
// - Software mode bits ignored unless select set
// - Byte1[1:0] selects output amplitude, reset 10
// - Byte2 bit n sets output n edge rate
// - Byte3 bit0 sets feedback edge rate
// - Frequency change only when byte3 bit5 set
// - Frequency code ignored unless enable set
// - Byte4 reserved, always reads all ones
// - Byte5 holds revision and maker codes
// - Byte6 holds product type and part codes
// - Byte7[4:0] sets the count byte of a block read, default 8; data bytes continue until stop
// - Block read returns count then data bytes
`timescale 1ns/100ps
module clock_buffer_cfg_bank #(
    // Arbitrary identification values
    parameter logic [3:0] REVISION_CODE = 4'h3,
    parameter logic [3:0] MAKER_CODE    = 4'h5,
    parameter logic [1:0] PRODUCT_TYPE  = 2'h3,
    parameter logic [5:0] PART_CODE     = 6'h15
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Strap pins
    input  wire logic [1:0]              strap_pll_mode,
    // Byte engine side
    input  wire clkbuf_cfg_pkg::req_type bus_req,
    output clkbuf_cfg_pkg::rsp_type      bus_rsp,
    // Analog and PLL controls
    output clkbuf_cfg_pkg::ctrl_type     ctrl,
    output logic                         strap_latched
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        clkbuf_cfg_pkg::phase_type phase;
        logic [7:0]                ptr;
        logic [7:0]                remain;
        clkbuf_cfg_pkg::rsp_type   rsp;
        clkbuf_cfg_pkg::ctrl_type  ctrl;
        logic [1:0]                strap_val;
        logic                      strap_done;
        logic [1:0]                strap_wait;
    } bank_state_type;

    bank_state_type st_r;
    bank_state_type st_nxt;

    logic [1:0] strap_sync_val;
    logic [7:0] b1_q;
    logic [7:0] b2_q;
    logic [7:0] b3_q;
    logic [7:0] b7_q;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------------
    // Strap input and byte registers
    // ------------------------------------------------------------------
    strap_sync #(.W(2)) u_strap_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (strap_pll_mode),
        .sync_out (strap_sync_val)
    );

    // A data byte is accepted only inside the count the host announced
    assign wr_hit = bus_req.valid && (bus_req.op == clkbuf_cfg_pkg::OP_WRITE)
                    && (st_r.phase == clkbuf_cfg_pkg::PH_WR_DATA)
                    && (st_r.remain != 8'h00);
    assign rd_hit = bus_req.valid && (bus_req.op == clkbuf_cfg_pkg::OP_READ);

    // Readback bits are live from the latch, never from the write path
    cfg_byte_reg #(
        .RESET (clkbuf_cfg_pkg::RST_PLL_AMP),
        .WMASK (clkbuf_cfg_pkg::WMASK_PLL_AMP)
    ) u_b1 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .we       (wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_PLL_AMP)),
        .wdata    (bus_req.data),
        .ro_bits  ({st_r.strap_val, 6'h00} | clkbuf_cfg_pkg::FIX_PLL_AMP),
        .q        (b1_q)
    );

    cfg_byte_reg #(
        .RESET (clkbuf_cfg_pkg::RST_SLEW),
        .WMASK (clkbuf_cfg_pkg::WMASK_SLEW)
    ) u_b2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .we       (wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_SLEW)),
        .wdata    (bus_req.data),
        .ro_bits  (8'h00),
        .q        (b2_q)
    );

    cfg_byte_reg #(
        .RESET (clkbuf_cfg_pkg::RST_FREQ),
        .WMASK (clkbuf_cfg_pkg::WMASK_FREQ)
    ) u_b3 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .we       (wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_FREQ)),
        .wdata    (bus_req.data),
        .ro_bits  (clkbuf_cfg_pkg::FIX_FREQ),
        .q        (b3_q)
    );

    cfg_byte_reg #(
        .RESET (clkbuf_cfg_pkg::RST_RD_LEN),
        .WMASK (clkbuf_cfg_pkg::WMASK_RD_LEN)
    ) u_b7 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .we       (wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_RD_LEN)),
        .wdata    (bus_req.data),
        .ro_bits  (8'h00),
        .q        (b7_q)
    );

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (st_r.ptr)
            clkbuf_cfg_pkg::OFS_PLL_AMP:   rd_byte = b1_q;
            clkbuf_cfg_pkg::OFS_SLEW:      rd_byte = b2_q;
            clkbuf_cfg_pkg::OFS_FREQ:      rd_byte = b3_q;
            clkbuf_cfg_pkg::OFS_RSVD:      rd_byte = clkbuf_cfg_pkg::RSVD_VALUE;
            clkbuf_cfg_pkg::OFS_REV_MAKER: rd_byte = {REVISION_CODE, MAKER_CODE};
            clkbuf_cfg_pkg::OFS_TYPE_PART: rd_byte = {PRODUCT_TYPE, PART_CODE};
            clkbuf_cfg_pkg::OFS_RD_LEN:    rd_byte = b7_q;
            default:                       rd_byte = clkbuf_cfg_pkg::UNMAPPED_VALUE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer and control outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.rsp.valid = 1'b0;
        st_nxt.rsp.ack   = 1'b0;

        // Strap is caught once, after the synchroniser has settled
        if (!st_r.strap_done)
        begin
            if (st_r.strap_wait == clkbuf_cfg_pkg::STRAP_SETTLE_CYC)
            begin
                st_nxt.strap_val  = strap_sync_val;
                st_nxt.strap_done = 1'b1;
            end
            else
                st_nxt.strap_wait = st_r.strap_wait + 2'h1;
        end

        if (bus_req.valid)
        begin
            unique case (bus_req.op)
                clkbuf_cfg_pkg::OP_INDEX:
                begin
                    st_nxt.ptr       = bus_req.data;
                    st_nxt.phase     = clkbuf_cfg_pkg::PH_WR_COUNT;
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.ack   = 1'b1;
                end
                clkbuf_cfg_pkg::OP_WRITE:
                begin
                    st_nxt.rsp.valid = 1'b1;
                    if (st_r.phase == clkbuf_cfg_pkg::PH_WR_COUNT)
                    begin
                        st_nxt.remain  = bus_req.data;
                        st_nxt.phase   = clkbuf_cfg_pkg::PH_WR_DATA;
                        st_nxt.rsp.ack = 1'b1;
                    end
                    else if (wr_hit)
                    begin
                        st_nxt.ptr     = st_r.ptr + 8'h01;
                        st_nxt.remain  = st_r.remain - 8'h01;
                        st_nxt.rsp.ack = 1'b1;
                    end
                end
                clkbuf_cfg_pkg::OP_READ_START:
                begin
                    st_nxt.phase     = clkbuf_cfg_pkg::PH_RD_COUNT;
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.ack   = 1'b1;
                end
                clkbuf_cfg_pkg::OP_READ:
                begin
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.data  = clkbuf_cfg_pkg::NO_DATA_VALUE;
                    if (st_r.phase == clkbuf_cfg_pkg::PH_RD_COUNT)
                    begin
                        // Count goes first, the data bytes follow
                        st_nxt.rsp.data = b7_q;
                        st_nxt.rsp.ack  = 1'b1;
                        st_nxt.phase    = clkbuf_cfg_pkg::PH_RD_DATA;
                    end
                    else if (st_r.phase == clkbuf_cfg_pkg::PH_RD_DATA)
                    begin
                        st_nxt.rsp.data = rd_byte;
                        st_nxt.rsp.ack  = 1'b1;
                        st_nxt.ptr      = st_r.ptr + 8'h01;
                    end
                end
                clkbuf_cfg_pkg::OP_STOP:
                    st_nxt.phase = clkbuf_cfg_pkg::PH_IDLE;
                default:
                    st_nxt.phase = st_r.phase;
            endcase
        end

        // Strap mode unless software select is set
        st_nxt.ctrl.pll_mode       = b1_q[clkbuf_cfg_pkg::PLL_SW_SEL]
                                     ? b1_q[clkbuf_cfg_pkg::PLL_SW_HI:clkbuf_cfg_pkg::PLL_SW_LO]
                                     : b1_q[clkbuf_cfg_pkg::PLL_RB_HI:clkbuf_cfg_pkg::PLL_RB_LO];
        st_nxt.ctrl.amplitude      = b1_q[clkbuf_cfg_pkg::AMP_HI:clkbuf_cfg_pkg::AMP_LO];
        st_nxt.ctrl.out_edge_rate  = b2_q;
        st_nxt.ctrl.fb_edge_rate   = b3_q[clkbuf_cfg_pkg::FB_SLEW];
        st_nxt.ctrl.freq_change_en = b3_q[clkbuf_cfg_pkg::FSEL_EN];
        // Code is held at zero while disabled so the PLL never sees a stale value
        st_nxt.ctrl.freq_code      = b3_q[clkbuf_cfg_pkg::FSEL_EN]
                                     ? b3_q[clkbuf_cfg_pkg::FCODE_HI:clkbuf_cfg_pkg::FCODE_LO]
                                     : 2'h0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r                     <= '0;
            st_r.phase               <= clkbuf_cfg_pkg::PH_IDLE;
            st_r.ctrl.amplitude      <= clkbuf_cfg_pkg::RST_PLL_AMP[1:0];
            st_r.ctrl.out_edge_rate  <= clkbuf_cfg_pkg::RST_SLEW;
            st_r.ctrl.fb_edge_rate   <= clkbuf_cfg_pkg::RST_FREQ[0];
        end
        else
            st_r <= st_nxt;
    end

    assign bus_rsp       = st_r.rsp;
    assign ctrl          = st_r.ctrl;
    assign strap_latched = st_r.strap_done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_b1;
        wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_PLL_AMP);
    endsequence
    sequence s_wr_b2;
        wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_SLEW);
    endsequence
    sequence s_wr_b3;
        wr_hit && (st_r.ptr == clkbuf_cfg_pkg::OFS_FREQ);
    endsequence
    sequence s_rd_at(logic [7:0] ofs);
        rd_hit && (st_r.phase == clkbuf_cfg_pkg::PH_RD_DATA) && (st_r.ptr == ofs);
    endsequence

    a_strap_readback: assert property (st_r.strap_done |=> $stable(st_r.strap_val)
        && (b1_q[7:6] == st_r.strap_val)) else $error("strap readback moved");
    a_sw_mode_used: assert property (b1_q[5] |=> ctrl.pll_mode == $past(b1_q[4:3]))
        else $error("software pll mode not applied");
    a_sw_bits_ignored: assert property ((!b1_q[5] && st_r.strap_done) [*2]
        |-> ctrl.pll_mode == st_r.strap_val) else $error("pll mode not from strap");
    a_amp_follows: assert property (s_wr_b1 |=> ##1 ctrl.amplitude == $past(bus_req.data[1:0], 2))
        else $error("amplitude not updated");
    a_slew_follows: assert property (s_wr_b2 |=> ##1 ctrl.out_edge_rate == $past(bus_req.data, 2))
        else $error("edge rate not updated");
    a_fb_slew: assert property (s_wr_b3 |=> ##1 ctrl.fb_edge_rate == $past(bus_req.data[0], 2))
        else $error("feedback edge rate not updated");
    a_freq_gated: assert property (!b3_q[5] |=> !ctrl.freq_change_en && (ctrl.freq_code == 2'h0))
        else $error("frequency code leaked while disabled");
    a_rsvd_ones: assert property (s_rd_at(clkbuf_cfg_pkg::OFS_RSVD) |=> bus_rsp.valid
        && (bus_rsp.data == 8'hFF)) else $error("reserved byte not all ones");
    a_rev_maker: assert property (s_rd_at(clkbuf_cfg_pkg::OFS_REV_MAKER) |=>
        bus_rsp.data == {REVISION_CODE, MAKER_CODE}) else $error("revision byte wrong");
    a_type_part: assert property (s_rd_at(clkbuf_cfg_pkg::OFS_TYPE_PART) |=>
        bus_rsp.data == {PRODUCT_TYPE, PART_CODE}) else $error("part byte wrong");
    a_count_first: assert property (rd_hit && (st_r.phase == clkbuf_cfg_pkg::PH_RD_COUNT)
        |=> bus_rsp.valid && bus_rsp.ack && (bus_rsp.data == $past(b7_q))
        && (st_r.phase == clkbuf_cfg_pkg::PH_RD_DATA)) else $error("count not first");
    a_ro_untouched: assert property (s_wr_b1 |=> (b1_q[7:6] == $past(b1_q[7:6])) && b1_q[2])
        else $error("read-only bits changed by write");
endmodule // clock_buffer_cfg_bank

// >>> tb/smbus_host_model.sv
/*
 Host controller model on the byte engine side of the configuration bank.
 Assumes the bank answers on the same edge that takes a request.
*/
`timescale 1ns/100ps
module smbus_host_model (
    // Clock
    input  wire logic                    core_clk,
    // Byte engine side
    output clkbuf_cfg_pkg::req_type      bus_req,
    input  wire clkbuf_cfg_pkg::rsp_type bus_rsp
);
    initial bus_req = '0;

    // ------------------------------------------------------------------
    // One byte event; STOP expects no answer
    // ------------------------------------------------------------------
    task automatic xfer(input clkbuf_cfg_pkg::op_type op, input logic [7:0] d,
                        input int gap, output logic ack, output logic [7:0] rd,
                        output logic ok);
        int n;
        ok = (op == clkbuf_cfg_pkg::OP_STOP);
        ack = 1'b0;
        rd = 8'h00;
        // Slow host leaves idle cycles between events
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        bus_req <= '{valid: 1'b1, op: op, data: d};
        @(posedge core_clk);
        // Released byte no longer carries the last value
        bus_req <= '{valid: 1'b0, op: clkbuf_cfg_pkg::OP_NONE, data: ~d};
        for (n = 0; n < 4 && !ok; n++)
        begin
            // Answer stands one cycle only; look mid-cycle while it is settled
            @(negedge core_clk);
            if (bus_rsp.valid === 1'b1)
            begin
                ok = 1'b1;
                ack = bus_rsp.ack;
                rd = bus_rsp.data;
            end
        end
    endtask
endmodule // smbus_host_model

// >>> tb/clock_buffer_cfg_bank_bench.sv
/*
 Self-checking bench for the configuration byte bank.
 Assumes the host model drives all byte events; strap pins are held static.
*/
`timescale 1ns/100ps
module clock_buffer_cfg_bank_bench;
    logic                     core_clk;
    logic                     rst_n;
    logic [1:0]               strap_pll_mode;
    clkbuf_cfg_pkg::req_type  bus_req;
    clkbuf_cfg_pkg::rsp_type  bus_rsp;
    clkbuf_cfg_pkg::ctrl_type ctrl;
    logic                     strap_latched;
    int                       failures;
    int                       n_checks;
    logic                     ack;
    logic [7:0]               rd;
    int                       gap;

    clock_buffer_cfg_bank dut_u (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .strap_pll_mode (strap_pll_mode),
        .bus_req        (bus_req),
        .bus_rsp        (bus_rsp),
        .ctrl           (ctrl),
        .strap_latched  (strap_latched)
    );

    smbus_host_model host_u (
        .core_clk (core_clk),
        .bus_req  (bus_req),
        .bus_rsp  (bus_rsp)
    );

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_op(input clkbuf_cfg_pkg::op_type op, input logic [7:0] d);
        logic ok;
        host_u.xfer(op, d, gap, ack, rd, ok);
        if (!ok)
        begin
            failures++;
            $display("Error answer timeout expected 1 seen 0");
            end_of_test();
        end
    endtask

    task automatic wr_block(input logic [7:0] start, input logic [7:0] b[$]);
        do_op(clkbuf_cfg_pkg::OP_INDEX, start);
        do_op(clkbuf_cfg_pkg::OP_WRITE, 8'(b.size()));
        foreach (b[i])
        begin
            do_op(clkbuf_cfg_pkg::OP_WRITE, b[i]);
            check("write ack", 16'(ack), 16'h0001);
        end
        do_op(clkbuf_cfg_pkg::OP_STOP, 8'h00);
        repeat (3) @(posedge core_clk);
    endtask

    task automatic rd_block(input logic [7:0] start, input logic [7:0] cnt,
                            input logic [7:0] b[$]);
        do_op(clkbuf_cfg_pkg::OP_INDEX, start);
        do_op(clkbuf_cfg_pkg::OP_READ_START, 8'h00);
        do_op(clkbuf_cfg_pkg::OP_READ, 8'h00);
        check("read count", 16'(rd), 16'(cnt));
        check("count ack", 16'(ack), 16'h0001);
        foreach (b[i])
        begin
            do_op(clkbuf_cfg_pkg::OP_READ, 8'h00);
            check("read byte", {7'h00, ack, rd}, {8'h01, b[i]});
        end
        do_op(clkbuf_cfg_pkg::OP_STOP, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        int n;
        for (n = 0; n < 10 && strap_latched !== 1'b1; n++)
            @(posedge core_clk);
        check("strap latched", 16'(strap_latched), 16'h0001);
        if (strap_latched !== 1'b1)
            end_of_test();
        repeat (2) @(posedge core_clk);
        // Strap mode 10, amplitude 10, all fast, no frequency change
        check("reset ctrl", ctrl, 16'hAFF8);
        rd_block(8'h01, 8'h08, '{8'h86, 8'hFF, 8'hC7, 8'hFF, 8'h35, 8'hD5, 8'h08});
        $display("test_reset done");
    endtask

    task automatic test_write();
        wr_block(8'h01, '{8'hFF, 8'h5A, 8'hFF});
        // Software mode 11, amplitude 11, frequency code live
        check("written ctrl", ctrl, 16'hF5AF);
        rd_block(8'h01, 8'h08, '{8'hBF, 8'h5A, 8'hFF});
        $display("test_write done");
    endtask

    task automatic test_gating();
        gap = 2;
        wr_block(8'h01, '{8'h18, 8'hA5, 8'h18});
        // Select bits cleared: software mode and code have no effect
        check("gated ctrl", ctrl, 16'h8A50);
        rd_block(8'h01, 8'h08, '{8'h9C, 8'hA5, 8'hDE});
        wr_block(8'h04, '{8'h00, 8'h00, 8'h00, 8'hFF});
        rd_block(8'h04, 8'h1F, '{8'hFF, 8'h35, 8'hD5, 8'h1F, 8'h00});
        gap = 0;
        $display("test_gating done");
    endtask

    task automatic test_refused();
        do_op(clkbuf_cfg_pkg::OP_WRITE, 8'h55);
        check("idle write ack", 16'(ack), 16'h0000);
        do_op(clkbuf_cfg_pkg::OP_READ, 8'h00);
        check("idle read", {7'h00, ack, rd}, 16'h00FF);
        do_op(clkbuf_cfg_pkg::OP_INDEX, 8'h02);
        do_op(clkbuf_cfg_pkg::OP_WRITE, 8'h01);
        do_op(clkbuf_cfg_pkg::OP_WRITE, 8'h11);
        do_op(clkbuf_cfg_pkg::OP_WRITE, 8'h22);
        check("past count ack", 16'(ack), 16'h0000);
        do_op(clkbuf_cfg_pkg::OP_STOP, 8'h00);
        rd_block(8'h02, 8'h1F, '{8'h11});
        $display("test_refused done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        strap_pll_mode = 2'h2;
        failures = 0;
        n_checks = 0;
        gap = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        test_reset();
        test_write();
        test_gating();
        test_refused();
        end_of_test();
    end
endmodule // clock_buffer_cfg_bank_bench
